// File: tas_regs.svh
`ifndef TAS_REGS_SVH
`define TAS_REGS_SVH
// register indices on the plain register port
`define TAS_A_ADC     6'h00
`define TAS_A_REF     6'h01
`define TAS_A_CFG     6'h02
`define TAS_A_STAT    6'h03
`define TAS_A_RES     6'h10
// converter control fields
`define TAS_ADC_MODE  15:13
`define TAS_ADC_CHAN  12:9
`define TAS_ADC_AVG   8:7
`define TAS_ADC_RES   6:5
`define TAS_ADC_DIV   4:3
`define TAS_ADC_SETL  2:0
// reference control fields
`define TAS_REF_HI    0
`define TAS_REF_CONT  1
`define TAS_REF_ON    2
// configuration fields
`define TAS_CFG_PRE   5:3
`define TAS_CFG_SNS   2:0
// status fields
`define TAS_ST_BUSY   0
`define TAS_ST_PEN    1
`define TAS_ST_NEW    12:4
// reset values
`define TAS_ADC_RST   16'h0000
`define TAS_REF_RST   16'h0004
`define TAS_CFG_RST   16'h0000
// scan modes
`define TAS_M_IDLE    3'h0
`define TAS_M_XY      3'h1
`define TAS_M_XYZ     3'h2
`define TAS_M_ONE     3'h3
`define TAS_M_DRV     3'h4
// channels, equal to result index
`define TAS_CH_X      4'h0
`define TAS_CH_Y      4'h1
`define TAS_CH_Z1     4'h2
`define TAS_CH_Z2     4'h3
`define TAS_CH_SE     4'h4
`define TAS_NCH       9
// timing
`define TAS_CLK_MHZ   250
`define TAS_INT_NS    125
`define TAS_INT_CYC   ((`TAS_INT_NS * `TAS_CLK_MHZ) / 1000)
`define TAS_DLY_TICKS 8
`define TAS_SMP_TICKS 3
`endif

// File: tas_pkg.sv
package tas_pkg;
  typedef enum logic [2:0] {
    ST_MON, ST_DRIVE, ST_SETTLE, ST_SAMPLE, ST_BITS, ST_STORE, ST_PRE, ST_SENSE
  } tas_state_e;

  typedef struct packed {
    logic        xp_hi;
    logic        xp_pull;
    logic        xp_pre;
    logic        xm_lo;
    logic        yp_hi;
    logic        ym_lo;
  } tas_drv_s;

  typedef struct packed {
    tas_drv_s    drv;
    logic        sample;
    logic [11:0] trial;
    logic [3:0]  nbits;
    logic [3:0]  chan;
    logic        diff;
    logic        ref_int;
    logic        ref_pwr;
    logic        ref_hi;
    logic        ext_ref;
  } tas_ana_s;

  typedef struct packed {
    logic [5:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tas_bus_s;

  typedef struct packed {
    tas_state_e          st;
    logic [15:0]         adc;
    logic [15:0]         refc;
    logic [15:0]         cfg;
    logic [8:0][11:0]    res;
    logic [8:0]          newf;
    logic [4:0]          pre;
    logic [2:0]          divc;
    logic [7:0]          cnt;
    logic [3:0]          bitn;
    logic [11:0]         acc;
    logic [15:0]         sum;
    logic [4:0]          nsamp;
    logic [3:0]          chan;
    logic [15:0]         rdata;
    logic                ready_n;
    logic                irq_n;
    tas_ana_s            ana;
  } tas_state_s;
endpackage : tas_pkg

// File: tas_top.sv
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ns
// Function
// - one control register sets channel, scan, averaging, resolution, rate
// - each result lands in its channel's register
// - results are unsigned straight binary codes
// - reference level selectable between two values
// - reference auto power-down or stays on
// - touch measurements always differential ratiometric
// - internal reference only for single-ended inputs
// - three resolutions, fewer bits take fewer clocks
// - conversion clock divided from internal clock
// - monitoring: Y- grounded, X+ pulled up, irq follows
// - touch pulls irq output low while monitoring; in XY and XYZ modes a touch starts the scan and irq stays high
// - X+ detached from irq during measurement
// - recheck restores monitoring drivers before sensing
// - precharge then sense, programmable times
// - other drivers off while precharging
// - data ready low until all new data read
// - internal reference can be off for external
// - settle delay after drivers on, before convert
`include "tas_regs.svh"
module tas_top (
  input  wire logic             clk_sys_in,       // system clock
  input  wire logic             rst_in,           // async reset, high
  input  wire tas_pkg::tas_bus_s bus_in,          // register port request
  output logic [15:0]           rdata_out,        // read data, cycle after strobe
  input  wire logic             pen_sense_in,     // X+ level, low when touched
  input  wire logic             cmp_in,           // comparator: input at or above trial
  output tas_pkg::tas_ana_s     ana_out,          // panel drivers, mux, sar, reference
  output logic                  pen_touch_irq_n_out, // pen touch, low active
  output logic                  result_ready_n_out   // new data pending, low active
);
  import tas_pkg::*;

  localparam logic [4:0] INT_LAST = 5'(`TAS_INT_CYC - 1);

  tas_state_s s;
  tas_state_s n;

  // divider ratios 1,2,4,8
  function automatic logic [2:0] div_last(input logic [1:0] d);
    unique case (d)
      2'h0: div_last = 3'h0;
      2'h1: div_last = 3'h1;
      2'h2: div_last = 3'h3;
      2'h3: div_last = 3'h7;
    endcase
  endfunction : div_last

  function automatic logic [3:0] res_bits(input logic [1:0] r);
    unique case (r)
      2'h1:    res_bits = 4'h8;
      2'h2:    res_bits = 4'hA;
      default: res_bits = 4'hC;
    endcase
  endfunction : res_bits

  function automatic logic [2:0] avg_shift(input logic [1:0] a);
    unique case (a)
      2'h0: avg_shift = 3'h0;
      2'h1: avg_shift = 3'h2;
      2'h2: avg_shift = 3'h3;
      2'h3: avg_shift = 3'h4;
    endcase
  endfunction : avg_shift

  function automatic logic [7:0] delay_ticks(input logic [2:0] c);
    delay_ticks = 8'(({5'h00, c} + 8'h01) * 8'(`TAS_DLY_TICKS));
  endfunction : delay_ticks

  function automatic tas_drv_s drv_for(input logic [3:0] ch);
    drv_for = '0;
    unique case (ch)
      `TAS_CH_X: begin
        drv_for.xp_hi = 1'b1;
        drv_for.xm_lo = 1'b1;
      end
      `TAS_CH_Y: begin
        drv_for.yp_hi = 1'b1;
        drv_for.ym_lo = 1'b1;
      end
      `TAS_CH_Z1, `TAS_CH_Z2: begin
        drv_for.yp_hi = 1'b1;
        drv_for.xm_lo = 1'b1;
      end
      default: drv_for = '0;
    endcase
  endfunction : drv_for

  logic       int_tick;
  logic       conv_tick;
  logic [2:0] mode;
  logic       self_mode;
  logic [3:0] last_ch;
  logic [3:0] ridx;

  always_comb begin
    n = s;
    n.rdata = 16'h0000;
    mode = s.adc[`TAS_ADC_MODE];
    self_mode = (mode == `TAS_M_XY) || (mode == `TAS_M_XYZ);
    last_ch = (mode == `TAS_M_XYZ) ? `TAS_CH_Z2 : `TAS_CH_Y;
    ridx = 4'(bus_in.addr - `TAS_A_RES);

    // internal 8 MHz tick, conversion tick divided from it
    int_tick = (s.pre == INT_LAST);
    n.pre = int_tick ? 5'h00 : 5'(s.pre + 5'h01);
    conv_tick = int_tick && (s.divc == div_last(s.adc[`TAS_ADC_DIV]));
    if (int_tick) begin
      n.divc = conv_tick ? 3'h0 : 3'(s.divc + 3'h1);
    end

    unique case (s.st)
      ST_MON: begin
        if (self_mode && s.ana.drv.xp_pull && !pen_sense_in) begin
          n.st = ST_SETTLE;
          n.chan = `TAS_CH_X;
          n.cnt = delay_ticks(s.adc[`TAS_ADC_SETL]);
          n.sum = 16'h0000;
          n.nsamp = 5'h00;
        end
      end
      ST_DRIVE: begin
        n.st = ST_DRIVE;
      end
      ST_SETTLE: begin
        if (int_tick) begin
          n.cnt = 8'(s.cnt - 8'h01);
          if (s.cnt == 8'h01) begin
            n.st = ST_SAMPLE;
            n.cnt = 8'(`TAS_SMP_TICKS);
          end
        end
      end
      ST_SAMPLE: begin
        if (conv_tick) begin
          n.cnt = 8'(s.cnt - 8'h01);
          if (s.cnt == 8'h01) begin
            n.st = ST_BITS;
            n.bitn = 4'(res_bits(s.adc[`TAS_ADC_RES]) - 4'h1);
            n.acc = 12'h000;
            n.acc[4'(res_bits(s.adc[`TAS_ADC_RES]) - 4'h1)] = 1'b1;
          end
        end
      end
      ST_BITS: begin
        if (conv_tick) begin
          // successive approximation, msb first, straight binary
          if (!cmp_in) begin
            n.acc[s.bitn] = 1'b0;
          end
          if (s.bitn != 4'h0) begin
            n.acc[4'(s.bitn - 4'h1)] = 1'b1;
            n.bitn = 4'(s.bitn - 4'h1);
          end else begin
            n.sum = 16'(s.sum + {4'h0, n.acc});
            n.nsamp = 5'(s.nsamp + 5'h01);
            if (n.nsamp == (5'h01 << avg_shift(s.adc[`TAS_ADC_AVG]))) begin
              n.st = ST_STORE;
            end else begin
              n.st = ST_SAMPLE;
              n.cnt = 8'(`TAS_SMP_TICKS);
            end
          end
        end
      end
      ST_STORE: begin
        n.res[s.chan] = 12'(s.sum >> avg_shift(s.adc[`TAS_ADC_AVG]));
        n.sum = 16'h0000;
        n.nsamp = 5'h00;
        if (!self_mode) begin
          n.st = ST_MON;
        end else if (s.chan != last_ch) begin
          n.st = ST_SETTLE;
          n.chan = 4'(s.chan + 4'h1);
          n.cnt = delay_ticks(s.adc[`TAS_ADC_SETL]);
        end else begin
          n.st = ST_PRE;
          n.cnt = delay_ticks(s.cfg[`TAS_CFG_PRE]);
        end
      end
      ST_PRE: begin
        if (int_tick) begin
          n.cnt = 8'(s.cnt - 8'h01);
          if (s.cnt == 8'h01) begin
            n.st = ST_SENSE;
            n.cnt = delay_ticks(s.cfg[`TAS_CFG_SNS]);
          end
        end
      end
      ST_SENSE: begin
        if (int_tick) begin
          n.cnt = 8'(s.cnt - 8'h01);
          if (s.cnt == 8'h01) begin
            if (!pen_sense_in) begin
              n.st = ST_SETTLE;
              n.chan = `TAS_CH_X;
              n.cnt = delay_ticks(s.adc[`TAS_ADC_SETL]);
            end else begin
              n.st = ST_MON;
            end
          end
        end
      end
    endcase

    // register writes; a control write restarts the sequencer
    if (bus_in.wr) begin
      unique case (bus_in.addr)
        `TAS_A_ADC: begin
          n.adc = bus_in.wdata;
          n.chan = bus_in.wdata[`TAS_ADC_CHAN];
          n.sum = 16'h0000;
          n.nsamp = 5'h00;
          if (bus_in.wdata[`TAS_ADC_MODE] == `TAS_M_ONE) begin
            n.st = ST_SETTLE;
            n.cnt = delay_ticks(bus_in.wdata[`TAS_ADC_SETL]);
          end else if (bus_in.wdata[`TAS_ADC_MODE] == `TAS_M_DRV) begin
            n.st = ST_DRIVE;
          end else begin
            n.st = ST_MON;
          end
        end
        `TAS_A_REF: n.refc = bus_in.wdata;
        `TAS_A_CFG: n.cfg = bus_in.wdata;
        default: n.refc = n.refc;
      endcase
    end

    // reads; the clear of a pending flag loses to a store in the same cycle
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        `TAS_A_ADC:  n.rdata = s.adc;
        `TAS_A_REF:  n.rdata = s.refc;
        `TAS_A_CFG:  n.rdata = s.cfg;
        `TAS_A_STAT: begin
          n.rdata[`TAS_ST_BUSY] = (s.st != ST_MON) && (s.st != ST_DRIVE);
          n.rdata[`TAS_ST_PEN] = !pen_sense_in;
          n.rdata[`TAS_ST_NEW] = s.newf;
        end
        default: begin
          // full-width bound, so higher indices do not alias onto the results
          if (bus_in.addr >= `TAS_A_RES && bus_in.addr < 6'(`TAS_A_RES + `TAS_NCH)) begin
            n.rdata = {4'h0, s.res[ridx]};
            n.newf[ridx] = 1'b0;
          end
        end
      endcase
    end
    if (s.st == ST_STORE) begin
      n.newf[s.chan] = 1'b1;
    end
    n.ready_n = ~|n.newf;

    // analog side, registered from the next state
    n.ana = '0;
    n.ana.chan = n.chan;
    n.ana.nbits = res_bits(n.adc[`TAS_ADC_RES]);
    n.ana.trial = n.acc;
    n.ana.sample = (n.st == ST_SAMPLE);
    n.ana.diff = (n.chan < `TAS_CH_SE);
    n.ana.ref_hi = n.refc[`TAS_REF_HI];
    n.ana.ref_int = n.refc[`TAS_REF_ON] && !n.ana.diff;
    n.ana.ext_ref = !n.refc[`TAS_REF_ON] && !n.ana.diff;
    // auto mode powers the reference only while a single-ended conversion runs
    n.ana.ref_pwr = n.refc[`TAS_REF_ON] && (n.refc[`TAS_REF_CONT] ||
                    (n.ana.ref_int && n.st inside {ST_SETTLE, ST_SAMPLE, ST_BITS}));
    n.irq_n = 1'b1;
    unique case (n.st)
      ST_MON: begin
        n.ana.drv.ym_lo = 1'b1;
        n.ana.drv.xp_pull = 1'b1;
        // X+ floats until the pullup has been on for a cycle; no false irq after reset or a scan
        n.irq_n = pen_sense_in || !s.ana.drv.xp_pull;
      end
      ST_PRE: begin
        n.ana.drv.xp_pre = 1'b1;
      end
      ST_SENSE: begin
        n.ana.drv.ym_lo = 1'b1;
        n.ana.drv.xp_pull = 1'b1;
      end
      default: begin
        // pullup and irq path stay detached so no leakage skews the panel
        n.ana.drv = drv_for(n.chan);
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
      s.adc <= `TAS_ADC_RST;
      s.refc <= `TAS_REF_RST;
      s.cfg <= `TAS_CFG_RST;
      s.ready_n <= 1'b1;
      s.irq_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign rdata_out = s.rdata;
  assign ana_out = s.ana;
  assign pen_touch_irq_n_out = s.irq_n;
  assign result_ready_n_out = s.ready_n;
endmodule : tas_top

// File: tas_top_checker.sv
`timescale 1ns/1ns
module tas_top_checker (
  input  wire logic              clk_sys_in,          // system clock
  input  wire logic              rst_in,              // async reset, high
  input  wire tas_pkg::tas_bus_s bus_in,              // register port request
  input  wire logic [15:0]       rdata_out,           // read data
  input  wire logic              pen_sense_in,        // X+ level
  input  wire logic              cmp_in,              // comparator
  input  wire tas_pkg::tas_ana_s ana_out,             // analog controls
  input  wire logic              pen_touch_irq_n_out, // pen touch, low active
  input  wire logic              result_ready_n_out   // data ready, low active
);
  import tas_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  sequence s_pre_end;
    ana_out.drv.xp_pre ##1 !ana_out.drv.xp_pre;
  endsequence
  AST_RD_IDLE: assert property (!$past(bus_in.rd) |-> rdata_out == 16'h0000)
    else $error("read data outside read cycle");
  AST_IRQ_CAUSE: assert property (!pen_touch_irq_n_out |-> $past(!pen_sense_in))
    else $error("pen irq low without touch");
  AST_MON_DRV: assert property (!pen_touch_irq_n_out |->
    ana_out.drv.ym_lo && ana_out.drv.xp_pull && !ana_out.drv.xm_lo && !ana_out.drv.yp_hi)
    else $error("pen irq low outside monitoring drivers");
  AST_XY_DETACH: assert property (ana_out.sample && ana_out.chan < 4'h2 |->
    !ana_out.drv.xp_pull && !ana_out.drv.xp_pre && pen_touch_irq_n_out)
    else $error("pullup attached during position sample");
  AST_PRE_OFF: assert property (ana_out.drv.xp_pre |->
    !(ana_out.drv.xm_lo || ana_out.drv.yp_hi || ana_out.drv.ym_lo))
    else $error("driver on during precharge");
  AST_PRE_END: assert property (s_pre_end |-> ana_out.drv.xp_pull && ana_out.drv.ym_lo)
    else $error("sense without pullup after precharge");
  AST_TOUCH_DIFF: assert property (ana_out.sample && ana_out.chan < 4'h4 |->
    ana_out.diff && !ana_out.ref_int)
    else $error("touch sample not differential");
  AST_SE_REF: assert property (ana_out.ref_int |-> !ana_out.diff && ana_out.chan >= 4'h4)
    else $error("internal reference on touch input");
  AST_EXT_REF: assert property (ana_out.ext_ref |-> !ana_out.ref_int && !ana_out.ref_pwr)
    else $error("internal reference active with external");
  AST_NBITS: assert property (ana_out.sample |-> ana_out.nbits inside {4'd8, 4'd10, 4'd12})
    else $error("bad resolution while sampling");
  AST_READY_REL: assert property ($rose(result_ready_n_out) |->
    $past(bus_in.rd) || $past(bus_in.rd, 2))
    else $error("data ready released without read");
endmodule : tas_top_checker
bind tas_top tas_top_checker tas_top_checker_inst (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus_in(bus_in), .rdata_out(rdata_out),
  .pen_sense_in(pen_sense_in), .cmp_in(cmp_in), .ana_out(ana_out),
  .pen_touch_irq_n_out(pen_touch_irq_n_out), .result_ready_n_out(result_ready_n_out)
);

// File: tas_panel_model.sv
`timescale 1ns/1ns
module tas_panel_model (
  input  wire logic              clk_sys_in,    // system clock
  input  wire tas_pkg::tas_ana_s ana_in,        // device analog controls
  input  wire logic              touch_in,      // panel pressed
  input  wire logic [8:0][11:0]  level_in,      // full scale input codes
  output logic                   pen_sense_out, // X+ level
  output logic                   cmp_out        // comparator result
);
  import tas_pkg::*;
  logic        toggle = 1'b0;
  logic [11:0] lvl;
  always_ff @(posedge clk_sys_in) begin
    toggle <= ~toggle;
  end
  always_comb begin
    lvl = (ana_in.chan < 4'd9 && ana_in.nbits != 4'd0) ? level_in[ana_in.chan] >> (4'd12 - ana_in.nbits) : 12'h000;
    cmp_out = lvl >= ana_in.trial;
    // an unpulled X+ floats, so it must not look like a steady level
    if (ana_in.drv.xp_pull || ana_in.drv.xp_pre) begin
      pen_sense_out = !(touch_in && ana_in.drv.ym_lo && !ana_in.drv.xp_pre);
    end else begin
      pen_sense_out = toggle;
    end
  end
endmodule : tas_panel_model

// File: test_touch_adc_sequencer.sv
`timescale 1ns/1ns
`include "tas_regs.svh"
module test_touch_adc_sequencer;
  import tas_pkg::*;
  logic             clk_sys_in = 1'b0;
  logic             rst_in = 1'b1;
  tas_bus_s         bus = '0;
  logic [15:0]      rdata;
  logic             pen_sense;
  logic             cmp;
  logic             irq_n;
  logic             ready_n;
  logic             touch = 1'b0;
  tas_ana_s         ana;
  logic [8:0][11:0] level = '0;
  int               fail_count = 0;
  int               n_tests = 0;
  logic [15:0]      d;
  tas_top tas_top_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus_in(bus), .rdata_out(rdata),
    .pen_sense_in(pen_sense), .cmp_in(cmp), .ana_out(ana), .pen_touch_irq_n_out(irq_n),
    .result_ready_n_out(ready_n));
  tas_panel_model tas_panel_model_inst (.clk_sys_in(clk_sys_in), .ana_in(ana), .touch_in(touch),
    .level_in(level), .pen_sense_out(pen_sense), .cmp_out(cmp));
  initial begin
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge clk_sys_in) bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_sys_in) bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [15:0] v);
    @(posedge clk_sys_in) bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_sys_in) bus.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd
  // which: 0 data ready, 1 pen irq, 2 precharge on, 3 precharge off
  task automatic wait_for(input int which, output int n);
    logic hit;
    for (n = 0; n < 20000; n++) begin
      @(posedge clk_sys_in);
      #1;
      case (which)
        0: hit = !ready_n;
        1: hit = !irq_n;
        2: hit = ana.drv.xp_pre;
        default: hit = !ana.drv.xp_pre;
      endcase
      if (hit === 1'b1) return;
    end
    fail_count++;
    $display("mismatch wait %0d expected 1 seen 0", which);
    wrap_up();
  endtask : wait_for
  task automatic t_reset;
    rd(`TAS_A_ADC, d); chk("adc reset", `TAS_ADC_RST, d);
    rd(`TAS_A_REF, d); chk("ref reset", `TAS_REF_RST, d);
    rd(`TAS_A_CFG, d); chk("cfg reset", `TAS_CFG_RST, d);
    wr(6'h3F, 16'hFFFF);
    rd(6'h3F, d); chk("unmapped", 16'h0000, d);
    rd(6'h20, d);
    chk("result alias", 16'h0000, d);
    chk("flags idle", 16'h0003, {14'h0, irq_n, ready_n});
  endtask : t_reset
  task automatic t_ref;
    logic [15:0] v [4] = '{16'h0007, 16'h0006, 16'h0005, 16'h0000};
    logic [2:0]  e [4] = '{3'b110, 3'b010, 3'b100, 3'b001};
    // a single-ended channel, so the reference path is in use
    wr(`TAS_A_ADC, {`TAS_M_IDLE, `TAS_CH_SE, 9'h000});
    for (int i = 0; i < 4; i++) begin
      wr(`TAS_A_REF, v[i]);
      rd(`TAS_A_REF, d); chk("ref readback", v[i], d);
      chk("ref hi pwr ext", {13'h0, e[i]}, {13'h0, ana.ref_hi, ana.ref_pwr, ana.ext_ref});
    end
    wr(`TAS_A_REF, 16'h0004);
  endtask : t_ref
  task automatic t_single;
    logic [1:0] rs [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    int         wd [4] = '{8, 10, 12, 12};
    int         n;
    int         prev;
    prev = 0;
    // divide ratio rises with resolution, as software has to pair them
    for (int i = 0; i < 4; i++) begin
      level[4+i] = 12'(12'hA5C - 12'h123 * i);
      wr(`TAS_A_ADC, {`TAS_M_ONE, 4'(4 + i), 2'(i == 3), rs[i], 2'(i), 3'h0});
      wait_for(0, n);
      if (n <= prev) chk("conversion time order", 16'h0001, 16'h0000);
      prev = n;
      rd(`TAS_A_STAT, d);
      chk("status new flag", 16'(16'h0100 << i), d);
      rd(6'(`TAS_A_RES + 4 + i), d);
      chk("single result", 16'(level[4+i] >> (12 - wd[i])), d);
      chk("ready after read", 16'h0001, {15'h0, ready_n});
    end
  endtask : t_single
  task automatic t_touch;
    int n;
    level[0] = 12'h321;
    level[1] = 12'hCDE;
    wr(`TAS_A_CFG, 16'h0009);
    // plain monitoring first: a self mode leaves monitoring on the touch itself
    wr(`TAS_A_ADC, {`TAS_M_IDLE, 4'h0, 9'h000});
    @(posedge clk_sys_in) touch <= 1'b1;
    wait_for(1, n);
    chk("monitor drivers", 16'h0003, {14'h0, ana.drv.ym_lo, ana.drv.xp_pull});
    wr(`TAS_A_ADC, {`TAS_M_XY, 4'h0, 2'h0, 2'h0, 2'h2, 3'h0});
    wait_for(0, n);
    wait_for(2, n);
    @(posedge clk_sys_in) touch <= 1'b0;
    wait_for(3, n);
    // 16 ticks of 31 clocks, minus the two edges spent before counting starts
    if (n < 464 || n > 494) chk("precharge length", 16'd479, 16'(n));
    repeat (600) @(posedge clk_sys_in);
    #1 chk("back to monitor", 16'h0003, {14'h0, ana.drv.ym_lo, ana.drv.xp_pull});
    rd(`TAS_A_RES, d); chk("x result", 16'h0321, d);
    chk("ready after x", 16'h0000, {15'h0, ready_n});
    rd(6'(`TAS_A_RES + 1), d); chk("y result", 16'h0CDE, d);
    chk("ready after y", 16'h0001, {15'h0, ready_n});
  endtask : t_touch
  task automatic t_drive;
    wr(`TAS_A_ADC, {`TAS_M_DRV, `TAS_CH_Y, 9'h000});
    #1;
    chk("drive only drivers", 16'h0003, {10'h000, ana.drv});
    chk("drive irq idle", 16'h0001, {15'h0, irq_n});
    rd(`TAS_A_STAT, d);
    chk("drive not busy", 16'h0000, {15'h0, d[`TAS_ST_BUSY]});
  endtask : t_drive
  task automatic t_xyz;
    int n;
    level[2] = 12'h456;
    level[3] = 12'h9AB;
    wr(`TAS_A_ADC, {`TAS_M_XYZ, 4'h0, 2'h0, 2'h0, 2'h2, 3'h0});
    @(posedge clk_sys_in) touch <= 1'b1;
    wait_for(2, n);
    @(posedge clk_sys_in) touch <= 1'b0;
    rd(6'(`TAS_A_RES + 2), d);
    chk("z1 result", 16'h0456, d);
    rd(6'(`TAS_A_RES + 3), d);
    chk("z2 result", 16'h09AB, d);
    chk("ready with x y unread", 16'h0000, {15'h0, ready_n});
  endtask : t_xyz
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    t_reset();
    t_ref();
    t_single();
    t_drive();
    t_touch();
    t_xyz();
    wrap_up();
  end
endmodule : test_touch_adc_sequencer
